// >>> core/fbc_feature_ctrl.sv
// Behaviour
// - feature register clears to zero at reset
// - bit0 picks oscillator or shift clock timebase
// - bit1 write pulses restore of control registers
// - restore leaves digit data registers untouched
// - bit2 selects code-B or hex font
// - bit4 switches blinking off or on
// - bit5 selects 1 s or 2 s period
// - bit6 clears timing counter on latch rise
// - bit7 picks first blink phase on/off
// - latch updates addressed register, chain_pass_through changes none
module fbc_feature_ctrl
    import fbc_pkg::*;
#(
    parameter int HALF_SHORT = HALF_SHORT_CYC, // short half period
    parameter int HALF_LONG = HALF_LONG_CYC // long half period
)
(
    // clock and reset
    input logic ref_clk,
    input logic reset_n,
    // serial link pins
    input logic shift_clk_pin,
    input logic serial_in_pin,
    input logic latch_strobe,
    output logic serial_out_pin,
    // feature controls towards the display core
    output logic [7:0] feature_q,
    output logic ext_clk_sel,
    output logic hex_font_sel,
    output logic ctrl_restore,
    output logic timebase_tick,
    output logic display_on
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_N-1:0] sclk_s; // shift clock synchroniser
        logic [SYNC_N-1:0] sdi_s; // serial data synchroniser
        logic [SYNC_N-1:0] ld_s; // latch synchroniser
        logic sclk_f; // filtered shift clock level
        logic ld_f; // filtered latch level
        logic sdi_f; // filtered serial data level
        logic [SHIFT_W-1:0] sr; // input shift register
        logic [7:0] feat; // feature_control
        logic restore; // one-cycle restore pulse
        logic [CNT_W-1:0] cnt; // blink timing counter
        logic phase; // current blink phase, 1 = lit
    } fbc_state_t;

    fbc_state_t q_q; // registered state
    fbc_state_t q_d; // next state
    logic sclk_rise; // filtered shift clock rising edge
    logic ld_rise; // filtered latch rising edge
    logic tick; // timebase advance
    logic [CNT_W-1:0] half; // active half period in ticks
    logic [ADDR_W-1:0] addr; // address nibble held in shift reg

    // ---------------------------------------------------------------
    // edge detection on agreed synchroniser stages
    // ---------------------------------------------------------------
    assign sclk_rise = q_q.sclk_s[1] & q_q.sclk_s[2] & ~q_q.sclk_f;
    assign ld_rise = q_q.ld_s[1] & q_q.ld_s[2] & ~q_q.ld_f;
    assign addr = q_q.sr[ADDR_LSB +: ADDR_W];
    // external mode advances only on shift clock edges
    // internal mode ticks on every cycle of ref_clk
    assign tick = q_q.feat[B_EXT_CLK] ? sclk_rise : 1'h1;
    // half period follows the period choice
    assign half = q_q.feat[B_LONG_PER] ? CNT_W'(HALF_LONG)
        : CNT_W'(HALF_SHORT);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        // hold every field unless a branch below moves it
        q_d = q_q;
        // restore is a one-cycle pulse, low unless a write sets it
        q_d.restore = 1'h0;
        // synchronisers shift in the pin levels
        q_d.sclk_s = {q_q.sclk_s[1:0], shift_clk_pin};
        q_d.sdi_s = {q_q.sdi_s[1:0], serial_in_pin};
        q_d.ld_s = {q_q.ld_s[1:0], latch_strobe};
        // a level counts once stages two and three agree
        if (q_q.sclk_s[1] == q_q.sclk_s[2])
        begin
            q_d.sclk_f = q_q.sclk_s[2];
        end
        if (q_q.ld_s[1] == q_q.ld_s[2])
        begin
            q_d.ld_f = q_q.ld_s[2];
        end
        if (q_q.sdi_s[1] == q_q.sdi_s[2])
        begin
            q_d.sdi_f = q_q.sdi_s[2];
        end
        // shift in on shift clock rise, msb falls out
        if (sclk_rise)
        begin
            q_d.sr = {q_q.sr[SHIFT_W-2:0], q_q.sdi_f};
        end
        // timing counter advances per tick and wraps per half
        if (tick)
        begin
            if (q_q.cnt >= half - CNT_W'(1))
            begin
                q_d.cnt = '0;
                q_d.phase = ~q_q.phase;
            end
            else
            begin
                q_d.cnt = q_q.cnt + CNT_W'(1);
            end
        end
        // latch rise acts on the held command
        if (ld_rise)
        begin
            if (addr == ADDR_FEATURE)
            begin
                q_d.feat = q_q.sr[7:0] & FEATURE_MASK;
                // pulse only; digit data lives elsewhere
                q_d.restore = q_q.sr[B_RESTORE];
                // blinking switched on starts in chosen phase
                if (q_q.sr[B_BLINK_EN] && !q_q.feat[B_BLINK_EN])
                begin
                    q_d.cnt = '0;
                    q_d.phase = q_q.sr[B_START_ON];
                end
            end
            // chain_pass_through and foreign addresses leave feat alone; only the align step below acts on them
            if (q_q.feat[B_ALIGN])
            begin
                // align timing across chained devices
                q_d.cnt = '0;
                q_d.phase = q_d.feat[B_START_ON];
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            // synchronous reset: all fields zero, pins seen idle low
            q_q <= '0;
            q_q.feat <= FEATURE_RESET;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // link output is the msb, the bit that leaves the shift register on the next shift
    assign serial_out_pin = q_q.sr[SHIFT_W-1];
    // stands for the register read; bit 3 always reads zero
    assign feature_q = q_q.feat;
    // timebase and font selects come straight from flops
    assign ext_clk_sel = q_q.feat[B_EXT_CLK];
    assign hex_font_sel = q_q.feat[B_HEX_FONT];
    // restore pulse goes to the other control registers
    assign ctrl_restore = q_q.restore;
    assign timebase_tick = tick;
    // display lit unless blinking and in the dark phase
    assign display_on = ~q_q.feat[B_BLINK_EN] | q_q.phase;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    reset_clear_a:
        assert property ($past(!reset_n) |-> feature_q == 8'h00)
        else $error("feature register not clear after reset");
    int_timebase_a:
        assert property (!ext_clk_sel |-> timebase_tick)
        else $error("internal timebase missed a tick");
    ext_timebase_a:
        assert property (ext_clk_sel && !sclk_rise |-> !timebase_tick)
        else $error("external timebase ticked without edge");
    restore_pulse_a:
        assert property (ctrl_restore |->
            $past(ld_rise && addr == ADDR_FEATURE && q_q.sr[1]))
        else $error("restore pulse without a write of bit 1");
    font_sel_a:
        assert property (hex_font_sel == feature_q[2])
        else $error("font select does not follow bit 2");
    blink_off_a:
        assert property (!feature_q[4] |-> display_on)
        else $error("display dark with blinking off");
    period_bound_a:
        assert property (q_q.cnt < half || $changed(half))
        else $error("timing counter past half period");
    sync_clear_a:
        assert property (ld_rise && feature_q[6] |=> q_q.cnt == '0)
        else $error("latch rise did not clear counter");
    start_phase_a:
        assert property (ld_rise && feature_q[6] && feature_q[4]
            && addr != ADDR_FEATURE |=> display_on == feature_q[7])
        else $error("blink did not restart in chosen phase");
    noop_keep_a:
        assert property (ld_rise && addr == ADDR_NOOP |=> $stable(feature_q))
        else $error("chain_pass_through command changed the feature register");
    shift_out_a:
        assert property (sclk_rise |=> serial_out_pin == $past(q_q.sr[14]))
        else $error("serial output is not the shifted-out bit");

    // ---------------------------------------------------------------
    // link checks
    // ---------------------------------------------------------------
    // a filtered level moves only once stages two and three agree
    sclk_filter_a:
        assert property ($changed(q_q.sclk_f)
            |-> $past(q_q.sclk_s[1] == q_q.sclk_s[2]))
        else $error("shift clock level moved without agreement");
    latch_filter_a:
        assert property ($changed(q_q.ld_f)
            |-> $past(q_q.ld_s[1] == q_q.ld_s[2]))
        else $error("latch level moved without agreement");
    data_filter_a:
        assert property ($changed(q_q.sdi_f)
            |-> $past(q_q.sdi_s[1] == q_q.sdi_s[2]))
        else $error("serial data level moved without agreement");
    // the filtered data bit enters at the bottom of the register
    shift_in_a:
        assert property (sclk_rise |=> q_q.sr[0] == $past(q_q.sdi_f))
        else $error("shift register took the wrong data bit");
    // without a shift clock edge the register and output stand
    sr_hold_a:
        assert property (!sclk_rise |=> $stable(q_q.sr))
        else $error("shift register moved without a clock edge");
    shift_hold_a:
        assert property (!sclk_rise |=> $stable(serial_out_pin))
        else $error("serial output moved without a clock edge");

    // ---------------------------------------------------------------
    // write path checks
    // ---------------------------------------------------------------
    // a feature write stores the data byte with bit 3 masked
    feat_write_a:
        assert property (ld_rise && addr == ADDR_FEATURE
            |=> feature_q == ($past(q_q.sr[7:0]) & FEATURE_MASK))
        else $error("feature write did not store the data byte");
    // other addresses and quiet cycles leave the register alone
    foreign_keep_a:
        assert property (ld_rise && addr != ADDR_FEATURE
            |=> $stable(feature_q))
        else $error("foreign address changed the feature register");
    idle_keep_a:
        assert property (!ld_rise |=> $stable(feature_q))
        else $error("feature register moved without a latch");
    unused_zero_a:
        assert property (feature_q[3] == 1'h0)
        else $error("unused bit of the feature register is set");
    // restore fires for one cycle on a write with bit 1 set
    restore_fire_a:
        assert property (ld_rise && addr == ADDR_FEATURE
            && q_q.sr[B_RESTORE] |=> ctrl_restore)
        else $error("write of bit 1 gave no restore pulse");
    restore_width_a:
        assert property (ctrl_restore |=> !ctrl_restore)
        else $error("restore pulse longer than one cycle");
    // restore never reaches the feature register itself
    restore_keep_a:
        assert property (ctrl_restore |=> $stable(feature_q))
        else $error("restore changed the feature register");

    // ---------------------------------------------------------------
    // timing checks
    // ---------------------------------------------------------------
    ext_tick_a:
        assert property (ext_clk_sel && sclk_rise |-> timebase_tick)
        else $error("external timebase missed a shift clock edge");
    // the counter steps once per tick and wraps at the half period
    count_step_a:
        assert property (tick && !ld_rise && q_q.cnt < half - CNT_W'(1)
            |=> q_q.cnt == $past(q_q.cnt) + CNT_W'(1))
        else $error("timing counter did not step by one");
    phase_flip_a:
        assert property (tick && !ld_rise && q_q.cnt >= half - CNT_W'(1)
            |=> q_q.phase != $past(q_q.phase))
        else $error("blink phase did not turn at the half period");
    phase_hold_a:
        assert property (!tick && !ld_rise |=> $stable(q_q.phase))
        else $error("blink phase moved without a tick");
    // switching blinking on starts in the phase that bit 7 chose
    blink_start_a:
        assert property (ld_rise && addr == ADDR_FEATURE
            && q_q.sr[B_BLINK_EN] && !feature_q[B_BLINK_EN]
            |=> display_on == $past(q_q.sr[B_START_ON]))
        else $error("blinking did not start in the chosen phase");

    cov_feature_write: cover property (ld_rise && addr == ADDR_FEATURE);
    cov_noop_latch: cover property (ld_rise && addr == ADDR_NOOP);
    cov_phase_flip: cover property (feature_q[4] && $changed(q_q.phase));
    cov_restore: cover property (ctrl_restore);
    cov_ext_tick: cover property (ext_clk_sel && timebase_tick);
endmodule

// >>> core/fbc_pkg.sv
package fbc_pkg;
    // ---------------------------------------------------------------
    // command word layout
    // ---------------------------------------------------------------
    localparam int SHIFT_W = 16; // serial command word width
    localparam int ADDR_LSB = 8; // address nibble position
    localparam int ADDR_W = 4; // address nibble width
    localparam logic [3:0] ADDR_NOOP = 4'h0; // chain_pass_through
    localparam logic [3:0] ADDR_FEATURE = 4'he; // feature_control
    // ---------------------------------------------------------------
    // feature_control fields
    // ---------------------------------------------------------------
    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [7:0] FEATURE_MASK = 8'hf7; // unused_bit reads 0
    localparam int B_EXT_CLK = 0; // external timebase select
    localparam int B_RESTORE = 1; // control defaults restore
    localparam int B_HEX_FONT = 2; // font table choice
    localparam int B_BLINK_EN = 4; // flash toggle enable
    localparam int B_LONG_PER = 5; // flash period choice
    localparam int B_ALIGN = 6; // flash align on latch
    localparam int B_START_ON = 7; // flash initial phase
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000; // ref_clk rate
    localparam int HALF_SHORT_MS = 500; // 1 s period, half of it
    localparam int HALF_LONG_MS = 1000; // 2 s period, half of it
    localparam int HALF_SHORT_CYC = (CLK_HZ / 1000) * HALF_SHORT_MS;
    localparam int HALF_LONG_CYC = (CLK_HZ / 1000) * HALF_LONG_MS;
    localparam int CNT_W = 32; // timing counter width
    localparam int SYNC_N = 3; // pin synchroniser depth
endpackage

// >>> test/fbc_feature_ctrl_test.sv
module fbc_feature_ctrl_test
    import fbc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HS = 20; // shortened half periods
    localparam int HL = 40;
    // pins and device outputs
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic sclk, sdat, latch, mid, tail;
    logic [7:0] f_a, f_b;
    logic x_a, x_b, h_a, h_b, r_a, r_b, t_a, t_b, on_a, on_b;
    // mismatch, compare, restore and tick counters
    int err_count = 0;
    int checks_done = 0;
    int rc_a = 0, rc_b = 0, tc_a = 0, tc_b = 0, n = 0;
    always #10 ref_clk = ~ref_clk;
    fbc_host_model host_u (.ref_clk(ref_clk), .shift_clk_pin(sclk),
        .serial_in_pin(sdat), .latch_strobe(latch));
    // first device of the chain feeds the second one
    fbc_feature_ctrl #(.HALF_SHORT(HS), .HALF_LONG(HL)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .shift_clk_pin(sclk),
        .serial_in_pin(sdat), .latch_strobe(latch), .serial_out_pin(mid),
        .feature_q(f_a), .ext_clk_sel(x_a), .hex_font_sel(h_a),
        .ctrl_restore(r_a), .timebase_tick(t_a), .display_on(on_a));
    fbc_feature_ctrl #(.HALF_SHORT(HS), .HALF_LONG(HL)) dut2_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .shift_clk_pin(sclk),
        .serial_in_pin(mid), .latch_strobe(latch), .serial_out_pin(tail),
        .feature_q(f_b), .ext_clk_sel(x_b), .hex_font_sel(h_b),
        .ctrl_restore(r_b), .timebase_tick(t_b), .display_on(on_b));
    // tally restore pulses and timebase ticks
    always @(posedge ref_clk)
    begin
        rc_a += (r_a === 1'h1);
        rc_b += (r_b === 1'h1);
        tc_a += (t_a === 1'h1);
        tc_b += (t_b === 1'h1);
    end
    // compare and report
    task automatic check(logic [63:0] seen, logic [63:0] want);
        checks_done++;
        if (seen !== want)
        begin
            err_count++;
            $display("BAD %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // command word; top nibble is ignored by the device
    function automatic logic [15:0] wr(logic [3:0] a, logic [7:0] d);
        return {4'h5, a, d};
    endfunction
    // skip a lit phase, wait out the dark one, then count lit cycles
    task automatic lit_len(logic far, output int len);
        len = 0;
        repeat (99) if ((far ? on_b : on_a) === 1'b1) @(negedge ref_clk);
        repeat (99) if ((far ? on_b : on_a) !== 1'b1) @(negedge ref_clk);
        repeat (99) if ((far ? on_b : on_a) === 1'b1)
        begin
            @(negedge ref_clk);
            len++;
        end
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({f_a, f_b}, 16'h0000);
        // far device written, near device holds a chain_pass_through
        host_u.send_frame(wr(ADDR_FEATURE, 8'hff), wr(ADDR_NOOP, 8'h5a));
        @(negedge ref_clk);
        check({f_a, f_b}, {8'h00, FEATURE_MASK});
        check({h_b, x_b, h_a, x_a}, 4'hc);
        check({tail, mid}, 2'h0);
        check(rc_b, 1);
        tc_a = 0;
        tc_b = 0;
        repeat (50) @(negedge ref_clk);
        check({tc_a, tc_b}, {32'h32, 32'h0});
        host_u.send_frame(wr(ADDR_FEATURE, 8'h01), wr(ADDR_FEATURE, 8'h04));
        @(negedge ref_clk);
        check(tc_b, 32);
        check({h_a, f_a, f_b}, 17'h10401);
        // blink: near short and starting lit, far long and starting dark
        host_u.send_frame(wr(ADDR_FEATURE, 8'h30), wr(ADDR_FEATURE, 8'h90));
        @(negedge ref_clk);
        check({on_a, on_b}, 2'h2);
        lit_len(1'h0, n);
        check(n, HS);
        lit_len(1'h1, n);
        check(n, HL);
        // near device aligns to the latch, far one stops blinking
        host_u.send_frame(wr(ADDR_FEATURE, 8'h00), wr(ADDR_FEATURE, 8'h50));
        repeat (2)
        begin
            repeat (7) @(negedge ref_clk);
            host_u.send_frame(wr(ADDR_NOOP, 8'hff), wr(ADDR_NOOP, 8'h00));
            @(negedge ref_clk);
            check({on_a, on_b}, 2'h1);
            repeat (8) @(negedge ref_clk);
            check({on_a, on_b, f_a}, 10'h150);
        end
        check({rc_a, rc_b}, {32'h0, 32'h1});
        complete_run();
    end
    // watchdog cuts a hang short
    initial
    begin
        #200us;
        err_count++;
        complete_run();
    end
endmodule

// >>> test/fbc_host_model.sv
module fbc_host_model
(
    // pacing clock
    input wire logic ref_clk,
    // link pins; latch and shift clock are shared by the chain
    output logic shift_clk_pin,
    output logic serial_in_pin,
    output logic latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins start low; the shift clock runs only within frames
    initial {shift_clk_pin, serial_in_pin, latch_strobe} = 3'h0;
    // far word first, msb first; each pin phase lasts four cycles
    task automatic send_frame(logic [15:0] far_w, logic [15:0] near_w);
        logic [31:0] s;
        s = {far_w, near_w};
        for (int i = 31; i >= 0; i--)
        begin
            serial_in_pin <= s[i];
            repeat (4) @(posedge ref_clk);
            shift_clk_pin <= 1'h1;
            repeat (4) @(posedge ref_clk);
            shift_clk_pin <= 1'h0;
        end
        // released data line shows the inverse, never a stale bit
        serial_in_pin <= ~s[0];
        repeat (4) @(posedge ref_clk);
        latch_strobe <= 1'h1;
        repeat (4) @(posedge ref_clk);
        latch_strobe <= 1'h0;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
